// ===== core/pch_config_regs.sv
`timescale 1ns/1ps
// Overview of operation
// - Word 00h holds device id in 31:16, vendor id in 15:0, read-only, from EEPROM.
// - EEPROM values are recalled automatically once PCI reset is released.
// - Card information word at 28h is read-only; writes leave it unchanged.
// - Scratch word 40h keeps software bits 15:8; all other bits reserved.
// - Signature word 80h is a constant, read-only, ignoring writes.
// - Parity error detected flag bit 31 sets on any parity error, regardless of bit 6.
// - Signalled system error flag bit 30 sets whenever SERR# was driven.
// - Master abort received flag bit 29 sets when own master cycle master-aborts.
// - Target abort received flag bit 28 sets when a target aborts own cycle.
// - Devsel timing field 26:25 always reads 01, medium speed.
// - Data parity reported bit 24 sets only on PERR, bus master and parity enable.
// - Fast back-to-back capable bit 23 always reads one.
// - Capability list bit 20 always reads one, though the power management words at C0h and C4h read zero.
// - With bit 8 set, an address phase parity error drives SERR#.
// - Bit 6 set turns detected parity errors into a system error indication.
module pch_config_regs
  import pch_pkg::*;
#(
  // Arbitrary neutral value, not a real part signature
  parameter logic [31:0] SIGNATURE_VALUE = 32'h5a5a_0001
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cfg_rd_in,
  input  wire logic        cfg_wr_in,
  input  wire logic [7:0]  cfg_addr_in,
  input  wire logic [3:0]  cfg_be_in,
  input  wire logic [31:0] cfg_wdata_in,
  output logic      [31:0] cfg_rdata_out,
  output logic             cfg_ack_out,
  output logic             cfg_loaded_out,
  output logic             ee_rd_out,
  output logic      [1:0]  ee_word_out,
  input  wire logic [31:0] ee_data_in,
  input  wire logic        ee_valid_in,
  input  wire logic        parity_err_in,
  input  wire logic        addr_parity_err_in,
  input  wire logic        perr_seen_in,
  input  wire logic        bus_master_in,
  input  wire logic        master_abort_in,
  input  wire logic        target_abort_in,
  output logic             serr_n_out,
  output logic             serr_oe_out,
  output logic             sys_err_ind_out,
  output logic             io_space_en_out,
  output logic             mem_space_en_out,
  output logic             master_en_out
);

  // ==========================================================
  // State
  typedef struct packed {
    pch_load_t   ld_state;
    logic [31:0] ident;
    logic [31:0] subsys;
    logic [31:0] card_info;
    logic        cmd_io;
    logic        cmd_mem;
    logic        cmd_master;
    logic        parity_response_en;
    logic        system_error_response_en;
    logic        parity_error_detected;
    logic        system_error_signalled;
    logic        master_abort_received;
    logic        target_abort_received;
    logic        data_parity_reported;
    logic [7:0]  latency;
    logic [7:0]  line_size;
    logic [23:0] io_base;
    logic [21:0] mem_base;
    logic [7:0]  scratch;
    logic [7:0]  int_line;
    logic [31:0] rdata;
    logic        ack;
    logic        serr;
    logic        sys_ind;
  } pch_state_t;

  pch_state_t st_r;
  pch_state_t st_nxt;

  logic        loaded;
  logic        access;
  logic        wr_go;
  logic [7:0]  addr_w;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic [31:0] rd_word;
  logic [31:0] cmd_stat_word;
  logic        serr_fire;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  assign loaded = (st_r.ld_state == PCH_LD_DONE);
  assign access = (cfg_rd_in | cfg_wr_in) & loaded;
  assign wr_go  = cfg_wr_in & loaded;
  assign addr_w = {cfg_addr_in[7:2], 2'h0};
  assign wmask  = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}}, {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};

  // ==========================================================
  // Command and status word as software sees it
  always_comb begin
    cmd_stat_word                                            = '0;
    cmd_stat_word[PCH_CMD_IO_BIT]                            = st_r.cmd_io;
    cmd_stat_word[PCH_CMD_MEM_BIT]                           = st_r.cmd_mem;
    cmd_stat_word[PCH_CMD_MASTER_BIT]                        = st_r.cmd_master;
    cmd_stat_word[PCH_CMD_PARITY_BIT]                        = st_r.parity_response_en;
    cmd_stat_word[PCH_CMD_SERR_BIT]                          = st_r.system_error_response_en;
    cmd_stat_word[PCH_ST_CAP_BIT]                            = 1'b1;
    cmd_stat_word[PCH_ST_FB2B_BIT]                           = 1'b1;
    cmd_stat_word[PCH_ST_DPR_BIT]                            = st_r.data_parity_reported;
    cmd_stat_word[PCH_ST_DEVSEL_LSB+1:PCH_ST_DEVSEL_LSB]     = PCH_DEVSEL_MEDIUM;
    cmd_stat_word[PCH_ST_TABORT_BIT]                         = st_r.target_abort_received;
    cmd_stat_word[PCH_ST_MABORT_BIT]                         = st_r.master_abort_received;
    cmd_stat_word[PCH_ST_SERR_BIT]                           = st_r.system_error_signalled;
    cmd_stat_word[PCH_ST_PERR_BIT]                           = st_r.parity_error_detected;
  end

  // ==========================================================
  // Read multiplexer
  always_comb begin
    case (addr_w)
      PCH_OFS_IDENT:     rd_word = st_r.ident;
      PCH_OFS_CMD_STAT:  rd_word = cmd_stat_word;
      PCH_OFS_CLASS:     rd_word = PCH_CLASS_VALUE;
      PCH_OFS_LATENCY:   rd_word = {16'h0000, st_r.latency, st_r.line_size};
      PCH_OFS_IO_BASE:   rd_word = {st_r.io_base, PCH_IO_BASE_RST[7:0]};
      PCH_OFS_MEM_BASE:  rd_word = {st_r.mem_base, 10'h000};
      PCH_OFS_CARD_INFO: rd_word = st_r.card_info;
      PCH_OFS_SUBSYS:    rd_word = st_r.subsys;
      PCH_OFS_INT_CFG:   rd_word = {24'h00_0000, st_r.int_line};
      PCH_OFS_SCRATCH:   rd_word = {16'h0000, st_r.scratch, 8'h00};
      PCH_OFS_SIGNATURE: rd_word = SIGNATURE_VALUE;
      // Boot ROM and power management words are not modelled here and read zero
      default:           rd_word = 32'h0000_0000;
    endcase
  end

  assign wval = cfg_wdata_in & wmask;

  // ==========================================================
  // Next state
  always_comb begin
    st_nxt         = st_r;
    st_nxt.ack     = access;
    st_nxt.serr    = 1'b0;
    st_nxt.sys_ind = 1'b0;
    serr_fire      = addr_parity_err_in & st_r.system_error_response_en;

    // Recall runs once after every reset release; config access waits for it
    case (st_r.ld_state)
      PCH_LD_START: begin
        st_nxt.ld_state = PCH_LD_IDENT;
      end
      PCH_LD_IDENT: begin
        if (ee_valid_in) begin
          st_nxt.ident    = ee_data_in;
          st_nxt.ld_state = PCH_LD_SUBSYS;
        end
      end
      PCH_LD_SUBSYS: begin
        if (ee_valid_in) begin
          st_nxt.subsys   = ee_data_in;
          st_nxt.ld_state = PCH_LD_CARD;
        end
      end
      PCH_LD_CARD: begin
        if (ee_valid_in) begin
          st_nxt.card_info = ee_data_in;
          st_nxt.ld_state  = PCH_LD_DONE;
        end
      end
      PCH_LD_DONE: begin
        st_nxt.ld_state = PCH_LD_DONE;
      end
      default: begin
        st_nxt.ld_state = PCH_LD_START;
      end
    endcase

    if (access) begin
      st_nxt.rdata = rd_word;
    end

    if (wr_go) begin
      case (addr_w)
        PCH_OFS_CMD_STAT: begin
          if (cfg_be_in[0]) begin
            st_nxt.cmd_io             = cfg_wdata_in[PCH_CMD_IO_BIT];
            st_nxt.cmd_mem            = cfg_wdata_in[PCH_CMD_MEM_BIT];
            st_nxt.cmd_master         = cfg_wdata_in[PCH_CMD_MASTER_BIT];
            st_nxt.parity_response_en = cfg_wdata_in[PCH_CMD_PARITY_BIT];
          end
          if (cfg_be_in[1]) begin
            st_nxt.system_error_response_en = cfg_wdata_in[PCH_CMD_SERR_BIT];
          end
          // Status flags: writing one clears; the event set below still wins
          if (wval[PCH_ST_PERR_BIT]) begin
            st_nxt.parity_error_detected = 1'b0;
          end
          if (wval[PCH_ST_SERR_BIT]) begin
            st_nxt.system_error_signalled = 1'b0;
          end
          if (wval[PCH_ST_MABORT_BIT]) begin
            st_nxt.master_abort_received = 1'b0;
          end
          if (wval[PCH_ST_TABORT_BIT]) begin
            st_nxt.target_abort_received = 1'b0;
          end
          if (wval[PCH_ST_DPR_BIT]) begin
            st_nxt.data_parity_reported = 1'b0;
          end
        end
        PCH_OFS_LATENCY: begin
          if (cfg_be_in[0]) begin
            st_nxt.line_size = cfg_wdata_in[7:0];
          end
          if (cfg_be_in[1]) begin
            st_nxt.latency = cfg_wdata_in[15:8];
          end
        end
        PCH_OFS_IO_BASE: begin
          st_nxt.io_base = (st_r.io_base & ~wmask[31:8]) | wval[31:8];
        end
        PCH_OFS_MEM_BASE: begin
          st_nxt.mem_base = (st_r.mem_base & ~wmask[31:10]) | wval[31:10];
        end
        PCH_OFS_INT_CFG: begin
          if (cfg_be_in[0]) begin
            st_nxt.int_line = cfg_wdata_in[7:0];
          end
        end
        PCH_OFS_SCRATCH: begin
          if (cfg_be_in[1]) begin
            st_nxt.scratch = cfg_wdata_in[15:8];
          end
        end
        // Identity, card info, signature and reserved words drop writes
        default: begin
          st_nxt.scratch = st_r.scratch;
        end
      endcase
    end

    // Hardware events, applied after clears so that a set is never lost
    if (parity_err_in | addr_parity_err_in) begin
      st_nxt.parity_error_detected = 1'b1;
      st_nxt.sys_ind               = st_r.parity_response_en;
    end
    if (serr_fire) begin
      st_nxt.serr                   = 1'b1;
      st_nxt.system_error_signalled = 1'b1;
    end
    if (master_abort_in) begin
      st_nxt.master_abort_received = 1'b1;
    end
    if (target_abort_in) begin
      st_nxt.target_abort_received = 1'b1;
    end
    if (perr_seen_in & bus_master_in & st_r.parity_response_en) begin
      st_nxt.data_parity_reported = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_r                          <= '0;
      st_r.ld_state                 <= PCH_LD_START;
      st_r.cmd_io                   <= PCH_CMD_STAT_RST[PCH_CMD_IO_BIT];
      st_r.cmd_mem                  <= PCH_CMD_STAT_RST[PCH_CMD_MEM_BIT];
      st_r.cmd_master               <= PCH_CMD_STAT_RST[PCH_CMD_MASTER_BIT];
      st_r.parity_response_en       <= PCH_CMD_STAT_RST[PCH_CMD_PARITY_BIT];
      st_r.system_error_response_en <= PCH_CMD_STAT_RST[PCH_CMD_SERR_BIT];
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign cfg_rdata_out    = st_r.rdata;
  assign cfg_ack_out      = st_r.ack;
  assign cfg_loaded_out   = loaded;
  assign ee_rd_out        = (st_r.ld_state == PCH_LD_IDENT) | (st_r.ld_state == PCH_LD_SUBSYS) |
                            (st_r.ld_state == PCH_LD_CARD);
  assign ee_word_out      = (st_r.ld_state == PCH_LD_SUBSYS) ? PCH_EE_WORD_SUBSYS :
                            (st_r.ld_state == PCH_LD_CARD)   ? PCH_EE_WORD_CARD : PCH_EE_WORD_IDENT;
  // Open-drain pin: the level is always low, only the enable moves
  assign serr_n_out       = 1'b0;
  assign serr_oe_out      = st_r.serr;
  assign sys_err_ind_out  = st_r.sys_ind;
  assign io_space_en_out  = st_r.cmd_io;
  assign mem_space_en_out = st_r.cmd_mem;
  assign master_en_out    = st_r.cmd_master;

  // ==========================================================
  // Checks
  ident_read_a: assert property (
    cfg_rd_in && loaded && addr_w == PCH_OFS_IDENT |=> cfg_ack_out && cfg_rdata_out == st_r.ident)
    else $error("identity word read wrong");

  recall_req_a: assert property (
    (st_r.ld_state != PCH_LD_DONE && st_r.ld_state != PCH_LD_START) |-> ee_rd_out && !cfg_loaded_out)
    else $error("recall not requesting eeprom");

  card_info_ro_a: assert property (
    cfg_wr_in && loaded && addr_w == PCH_OFS_CARD_INFO |=> $stable(st_r.card_info))
    else $error("card info changed by write");

  scratch_wr_a: assert property (
    cfg_wr_in && loaded && addr_w == PCH_OFS_SCRATCH && cfg_be_in[1]
      |=> st_r.scratch == $past(cfg_wdata_in[15:8]))
    else $error("scratch byte not stored");

  signature_rd_a: assert property (
    cfg_rd_in && loaded && addr_w == PCH_OFS_SIGNATURE |=> cfg_rdata_out == SIGNATURE_VALUE)
    else $error("signature read wrong");

  parity_flag_a: assert property (
    parity_err_in |=> st_r.parity_error_detected)
    else $error("parity flag not set");

  serr_status_a: assert property (
    serr_oe_out |-> st_r.system_error_signalled)
    else $error("serr driven without status");

  master_abort_a: assert property (
    master_abort_in |=> st_r.master_abort_received)
    else $error("master abort flag not set");

  target_abort_a: assert property (
    target_abort_in |=> st_r.target_abort_received)
    else $error("target abort flag not set");

  status_fixed_a: assert property (
    cfg_rd_in && loaded && addr_w == PCH_OFS_CMD_STAT
      |=> cfg_rdata_out[26:25] == 2'h1 && cfg_rdata_out[23] && cfg_rdata_out[20])
    else $error("fixed status bits wrong");

  dpr_cause_a: assert property (
    $rose(st_r.data_parity_reported)
      |-> $past(perr_seen_in) && $past(bus_master_in) && $past(st_r.parity_response_en))
    else $error("data parity reported without cause");

  serr_drive_a: assert property (
    addr_parity_err_in && st_r.system_error_response_en |=> serr_oe_out ##1 !serr_oe_out || $past(serr_fire))
    else $error("serr not driven on address parity");

  reserved_rd_a: assert property (
    cfg_rd_in && loaded && addr_w == 8'h18 |=> cfg_rdata_out == 32'h0000_0000)
    else $error("reserved word not zero");

  sys_ind_a: assert property (
    parity_err_in && st_r.parity_response_en |=> sys_err_ind_out)
    else $error("system error indication missing");

endmodule : pch_config_regs

// ===== core/pch_pkg.sv
package pch_pkg;

  // ==========================================================
  // Register offsets (byte addresses of configuration words)
  localparam logic [7:0] PCH_OFS_IDENT      = 8'h00;
  localparam logic [7:0] PCH_OFS_CMD_STAT   = 8'h04;
  localparam logic [7:0] PCH_OFS_CLASS      = 8'h08;
  localparam logic [7:0] PCH_OFS_LATENCY    = 8'h0c;
  localparam logic [7:0] PCH_OFS_IO_BASE    = 8'h10;
  localparam logic [7:0] PCH_OFS_MEM_BASE   = 8'h14;
  localparam logic [7:0] PCH_OFS_CARD_INFO  = 8'h28;
  localparam logic [7:0] PCH_OFS_SUBSYS     = 8'h2c;
  localparam logic [7:0] PCH_OFS_BOOT_ROM   = 8'h30;
  localparam logic [7:0] PCH_OFS_INT_CFG    = 8'h3c;
  localparam logic [7:0] PCH_OFS_SCRATCH    = 8'h40;
  localparam logic [7:0] PCH_OFS_SIGNATURE  = 8'h80;
  localparam logic [7:0] PCH_OFS_PM_CAP     = 8'hc0;
  localparam logic [7:0] PCH_OFS_PM_CTRL    = 8'hc4;

  // ==========================================================
  // Command and status field positions
  localparam int PCH_CMD_IO_BIT      = 0;
  localparam int PCH_CMD_MEM_BIT     = 1;
  localparam int PCH_CMD_MASTER_BIT  = 2;
  localparam int PCH_CMD_PARITY_BIT  = 6;
  localparam int PCH_CMD_SERR_BIT    = 8;
  localparam int PCH_ST_CAP_BIT      = 20;
  localparam int PCH_ST_FB2B_BIT     = 23;
  localparam int PCH_ST_DPR_BIT      = 24;
  localparam int PCH_ST_DEVSEL_LSB   = 25;
  localparam int PCH_ST_TABORT_BIT   = 28;
  localparam int PCH_ST_MABORT_BIT   = 29;
  localparam int PCH_ST_SERR_BIT     = 30;
  localparam int PCH_ST_PERR_BIT     = 31;

  // ==========================================================
  // Reset and fixed values
  localparam logic [31:0] PCH_CMD_STAT_RST  = 32'h0290_0000;
  localparam logic [1:0]  PCH_DEVSEL_MEDIUM = 2'h1;
  localparam logic [31:0] PCH_CLASS_VALUE   = 32'h0200_0011;
  localparam logic [31:0] PCH_IO_BASE_RST   = 32'h0000_0001;
  localparam logic [1:0]  PCH_EE_WORD_IDENT = 2'h0;
  localparam logic [1:0]  PCH_EE_WORD_SUBSYS = 2'h1;
  localparam logic [1:0]  PCH_EE_WORD_CARD  = 2'h2;

  // ==========================================================
  // Recall sequencer states, Gray along the load path
  typedef enum logic [2:0] {
    PCH_LD_START  = 3'h0,
    PCH_LD_IDENT  = 3'h1,
    PCH_LD_SUBSYS = 3'h3,
    PCH_LD_CARD   = 3'h2,
    PCH_LD_DONE   = 3'h6
  } pch_load_t;

endpackage : pch_pkg

// ===== verification/pch_eeprom_model.sv
`timescale 1ns/1ps
// ==========================================================
// Serial EEPROM word source answering the recall sequencer
module pch_eeprom_model #(
  parameter int          WAIT_CYC = 2,
  parameter logic [31:0] IDENT_W  = 32'h0000_0000,
  parameter logic [31:0] SUBSYS_W = 32'h0000_0000,
  parameter logic [31:0] CARD_W   = 32'h0000_0000
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        ee_rd_in,
  input  wire logic [1:0]  ee_word_in,
  output logic      [31:0] ee_data_out,
  output logic             ee_valid_out
);
  int cnt_r;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_r        <= 0;
      ee_valid_out <= 1'b0;
      ee_data_out  <= 32'h0000_0000;
    end else begin
      ee_valid_out <= 1'b0;
      // Data is only meaningful with the strobe, so it toggles in between
      ee_data_out  <= ~ee_data_out;
      // Skip the cycle after a strobe: the word index has not advanced yet
      if (ee_rd_in && !ee_valid_out) begin
        if (cnt_r >= WAIT_CYC) begin
          cnt_r        <= 0;
          ee_valid_out <= 1'b1;
          case (ee_word_in)
            2'h0:    ee_data_out <= IDENT_W;
            2'h1:    ee_data_out <= SUBSYS_W;
            default: ee_data_out <= CARD_W;
          endcase
        end else begin
          cnt_r <= cnt_r + 1;
        end
      end
    end
  end
endmodule : pch_eeprom_model

// ===== verification/pci_config_header_regs_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin bad_count++; $display("ERROR %s expected %h got %h", nm, e, g); end end
module pci_config_header_regs_tb;
  import pch_pkg::*;
  localparam logic [31:0] SIG_VAL  = 32'h3c3c_0002; // Arbitrary value
  localparam logic [31:0] ID_W     = 32'h1357_2468; // Arbitrary value
  localparam logic [31:0] SUB_W    = 32'h0a0b_0c0d; // Arbitrary value
  localparam logic [31:0] CARD_W   = 32'h0000_7f41;
  logic        clk_in = 1'b0;
  logic        rst_r = 1'b1, cfg_rd_r = 1'b0, cfg_wr_r = 1'b0, bm_r = 1'b0;
  logic [7:0]  addr_r = 8'h00;
  logic [3:0]  be_r = 4'h0;
  logic [31:0] wdata_r = 32'h0, rnd = 32'h0000_0016, rd_v;
  logic [4:0]  ev_r = 5'h00;
  logic [7:0]  rsv [7] = '{8'h18, 8'h1c, 8'h20, 8'h24, 8'h34, 8'h38, 8'h84};
  wire  [31:0] cfg_rdata_out, ee_data;
  wire  [1:0]  ee_word;
  wire         cfg_ack_out, cfg_loaded_out, ee_rd, ee_valid, serr_n_out, serr_oe_out, sys_err_ind_out;
  wire         io_en, mem_en, mst_en;
  int          bad_count = 0, tests_run = 0, cyc = 0;

  always #12.5 clk_in = ~clk_in;

  pch_config_regs #(.SIGNATURE_VALUE(SIG_VAL)) u_dut (
    .clk_in(clk_in), .rst_in(rst_r), .cfg_rd_in(cfg_rd_r), .cfg_wr_in(cfg_wr_r), .cfg_addr_in(addr_r),
    .cfg_be_in(be_r), .cfg_wdata_in(wdata_r), .cfg_rdata_out(cfg_rdata_out), .cfg_ack_out(cfg_ack_out),
    .cfg_loaded_out(cfg_loaded_out), .ee_rd_out(ee_rd), .ee_word_out(ee_word), .ee_data_in(ee_data),
    .ee_valid_in(ee_valid), .parity_err_in(ev_r[0]), .addr_parity_err_in(ev_r[1]), .perr_seen_in(ev_r[2]),
    .bus_master_in(bm_r), .master_abort_in(ev_r[3]), .target_abort_in(ev_r[4]), .serr_n_out(serr_n_out),
    .serr_oe_out(serr_oe_out), .sys_err_ind_out(sys_err_ind_out), .io_space_en_out(io_en),
    .mem_space_en_out(mem_en), .master_en_out(mst_en));

  pch_eeprom_model #(.WAIT_CYC(2), .IDENT_W(ID_W), .SUBSYS_W(SUB_W), .CARD_W(CARD_W)) u_ee (
    .clk_in(clk_in), .rst_in(rst_r), .ee_rd_in(ee_rd), .ee_word_in(ee_word), .ee_data_out(ee_data),
    .ee_valid_out(ee_valid));

  // ==========================================================
  // Expectations
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // Flags packed as bits 31,30,29,28,24
  function automatic logic [31:0] exp_cs(input logic [4:0] fl, input logic [8:0] cmd);
    return PCH_CMD_STAT_RST | {fl[4:1], 3'h0, fl[0], 15'h0000, cmd};
  endfunction : exp_cs

  // ==========================================================
  // Bus tasks
  task automatic tally_and_finish;
    if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic cfg_xfer(input logic wr, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk_in);
    cfg_rd_r <= !wr;
    cfg_wr_r <= wr;
    addr_r   <= a;
    be_r     <= be;
    wdata_r  <= d;
    @(posedge clk_in);
    cfg_rd_r <= 1'b0;
    cfg_wr_r <= 1'b0;
    #1 `CHK("cfg_ack_out", 1'b1, cfg_ack_out)
    rd_v = cfg_rdata_out;
  endtask : cfg_xfer

  task automatic cfg_rd(input logic [7:0] a, input logic [31:0] e);
    cfg_xfer(1'b0, a, 4'h0, 32'h0);
    `CHK("cfg_rdata_out", e, rd_v)
  endtask : cfg_rd

  // Index: 0 data parity, 1 address parity, 2 perr seen, 3 master abort, 4 target abort
  task automatic ev_pulse(input int idx, input logic e_serr, input logic e_ind);
    @(posedge clk_in);
    ev_r <= 5'h01 << idx;
    @(posedge clk_in);
    ev_r <= 5'h00;
    #1 `CHK("serr_oe_out", e_serr, serr_oe_out)
    `CHK("sys_err_ind_out", e_ind, sys_err_ind_out)
    if (e_serr) `CHK("serr_n_out", 1'b0, serr_n_out)
  endtask : ev_pulse

  task automatic reset_and_load;
    // Reset is raised on an edge so that every input moves on the clock
    @(posedge clk_in) rst_r <= 1'b1;
    repeat (3) @(posedge clk_in);
    `CHK("cfg_loaded_out", 1'b0, cfg_loaded_out)
    rst_r <= 1'b0;
    @(posedge clk_in);
    cfg_rd_r <= 1'b1;
    @(posedge clk_in);
    cfg_rd_r <= 1'b0;
    #1 `CHK("ee_rd_out", 1'b1, ee_rd)
    `CHK("cfg_ack_out", 1'b0, cfg_ack_out)
    for (int i = 0; i < 100 && cfg_loaded_out !== 1'b1; i++) @(posedge clk_in);
    `CHK("cfg_loaded_out", 1'b1, cfg_loaded_out)
    cfg_rd(PCH_OFS_IDENT, ID_W);
    cfg_rd(PCH_OFS_CMD_STAT, PCH_CMD_STAT_RST);
  endtask : reset_and_load

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    reset_and_load();
    cfg_rd(PCH_OFS_SUBSYS, SUB_W);
    cfg_rd(PCH_OFS_CARD_INFO, CARD_W);
    cfg_rd(PCH_OFS_SIGNATURE, SIG_VAL);
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr_next(rnd);
      cfg_xfer(1'b1, PCH_OFS_CARD_INFO, 4'hf, rnd);
      cfg_rd(PCH_OFS_CARD_INFO, CARD_W);
      cfg_xfer(1'b1, PCH_OFS_IDENT, 4'hf, rnd);
      cfg_rd(PCH_OFS_IDENT, ID_W);
      cfg_xfer(1'b1, PCH_OFS_SIGNATURE, 4'hf, rnd);
      cfg_rd(PCH_OFS_SIGNATURE, SIG_VAL);
      cfg_xfer(1'b1, PCH_OFS_SCRATCH, 4'hf, rnd);
      cfg_rd(PCH_OFS_SCRATCH, rnd & 32'h0000_ff00);
      cfg_xfer(1'b1, PCH_OFS_SCRATCH, 4'hd, ~rnd);
      cfg_rd(PCH_OFS_SCRATCH, rnd & 32'h0000_ff00);
    end
    foreach (rsv[i]) begin
      cfg_xfer(1'b1, rsv[i], 4'hf, 32'hffff_ffff);
      cfg_rd(rsv[i], 32'h0000_0000);
    end
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'hf, 32'hffff_ffff);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h00, 9'h147));
    `CHK("command enables", 3'h7, {mst_en, mem_en, io_en})
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'hf, 32'h0000_0000);
    ev_pulse(0, 1'b0, 1'b0);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h10, 9'h000));
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'h8, 32'h8000_0000);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h00, 9'h000));
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'h1, 32'h0000_0040);
    ev_pulse(0, 1'b0, 1'b1);
    ev_pulse(1, 1'b0, 1'b1);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h10, 9'h040));
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'h2, 32'h0000_0100);
    ev_pulse(1, 1'b1, 1'b1);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h18, 9'h140));
    ev_pulse(3, 1'b0, 1'b0);
    ev_pulse(4, 1'b0, 1'b0);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h1e, 9'h140));
    cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'hf, 32'hf100_0000);
    cfg_rd(PCH_OFS_CMD_STAT, exp_cs(5'h00, 9'h000));
    for (int j = 0; j < 4; j++) begin
      cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'h1, j[0] ? 32'h0000_0040 : 32'h0000_0000);
      @(posedge clk_in) bm_r <= j[1];
      ev_pulse(2, 1'b0, 1'b0);
      cfg_rd(PCH_OFS_CMD_STAT, exp_cs({4'h0, j[0] & j[1]}, {2'h0, j[0], 6'h00}));
      cfg_xfer(1'b1, PCH_OFS_CMD_STAT, 4'h8, 32'h0100_0000);
    end
    reset_and_load();
    tally_and_finish();
  end
endmodule : pci_config_header_regs_tb
